// >>> common/asc_pkg.sv
// Purpose: shared constants and carriers for the slot integration config bank
// Assumes: 8-bit register index, 16-bit register data
// Notes:   offsets are the register indexes seen by the serial host port
package asc_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT_A_WINDOW    = 8'h39;
  localparam logic [7:0] OFS_SLOT_A_MODE_GAIN = 8'h42;
  localparam logic [7:0] OFS_SLOT_A_CH_GAIN   = 8'h55;
  localparam logic [7:0] OFS_INT_MODE_SELECT  = 8'h58;
  localparam logic [7:0] OFS_INT_SAMPLE_OPTS  = 8'h5A;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POS_SECOND_SLOT_INT   = 13;
  localparam int POS_FIRST_SLOT_INT    = 12;
  localparam int POS_GAP_ENABLE        = 7;
  localparam int POS_SECOND_SINGLE     = 6;
  localparam int POS_FIRST_SINGLE      = 5;
  localparam int POS_WIDTH_MSB         = 15;
  localparam int POS_WIDTH_LSB         = 11;
  localparam int POS_COARSE_MSB        = 10;
  localparam int POS_COARSE_LSB        = 5;
  localparam int POS_FINE_MSB          = 4;
  localparam int POS_FINE_LSB          = 0;
  localparam int POS_CHAIN_MSB         = 15;
  localparam int POS_CHAIN_LSB         = 8;
  localparam int POS_PER_CH_EN         = 6;
  localparam int POS_GAIN_MSB          = 1;
  localparam int POS_GAIN_LSB          = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0]  RST_WIDTH      = 5'h04;
  localparam logic [5:0]  RST_COARSE     = 6'h17;
  localparam logic [4:0]  RST_FINE       = 5'h1C;
  localparam logic [15:0] RST_WINDOW     = {RST_WIDTH, RST_COARSE, RST_FINE};
  localparam logic [15:0] RST_MODE_GAIN  = 16'h1C38;
  localparam logic [15:0] RST_CH_GAIN    = 16'h0000;
  localparam logic [15:0] RST_MODE_SEL   = 16'h0000;
  localparam logic [15:0] RST_SAMPLE_OPT = 16'h0000;

  // ----------------------------------------------------------------------
  // chain mode codes and step sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CHAIN_NORMAL    = 8'h1C;
  localparam logic [7:0]  CHAIN_DIGITAL   = 8'h1D;
  localparam logic [15:0] PATH_DIGITAL    = 16'hAE65;
  localparam int          WINDOW_STEP_NS  = 1000;
  localparam int          FINE_STEP_PS    = 31250;
  localparam int          CLK_PERIOD_NS   = 50;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } asc_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [15:0] rdata;
  } asc_rsp_t;

  typedef struct packed {
    logic             first_slot_integration_enable;
    logic             second_slot_integration_enable;
    logic             integration_gap_enable;
    logic             first_slot_single_pair;
    logic             second_slot_single_pair;
    logic [4:0]       first_slot_window_width;
    logic [5:0]       first_slot_window_coarse;
    logic [4:0]       first_slot_window_fine;
    logic [4:0]       first_slot_gap_us;
    logic [7:0]       first_slot_chain_mode;
    logic             first_slot_per_channel_gain_enable;
    logic [3:0][1:0]  first_slot_amp_gain;
    logic [3:0][7:0]  first_slot_amp_kohm;
  } asc_cfg_t;

endpackage : asc_pkg

// >>> rtl/asc_config_regs.sv
// Purpose: slot integration and front end config bank, time slot A window
// Assumes: host serial port delivers decoded single-cycle read/write requests
// Notes:   read data appears one cycle after the request, from a flop
//          chain mode code is stored, never checked, and the path connection code is not held here;
//          keeping them legal is up to software
//
// Summary of operation
// - bit 13 of mode select: slot B normal or digital integration
// - bit 12 of mode select: slot A normal or digital integration
// - gap bit 7: no gap, or fine offset gives the gap in us
// - options bit 6: slot B double (0) or single (1) sample pair
// - options bit 5: slot A double (0) or single (1) sample pair
// - window bits 15:11 width in 1 us steps, reset 4
// - window bits 10:5 coarse offset in 1 us steps, reset 0x17
// - window bits 4:0 fine offset in 31.25 ns steps, reset 0x1C
// - per-channel enable: ch1 from mode reg, ch2..4 from companion
// - gain code 0..3 is 200/100/50/25 kohm; shared when not per-channel
// - companion bits 1:0 ch2, higher pairs ch3 and ch4
`timescale 1ns/10ps
`default_nettype none
module asc_config_regs
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // register access from the serial host port
  input  wire asc_req_t req,
  output var  asc_rsp_t rsp,
  // decoded configuration to the slot timing and front end
  output var  asc_cfg_t cfg
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // writes to unmapped indexes match no register and are dropped
  function automatic logic hit(input asc_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [7:0] gain_kohm(input logic [1:0] code);
    case (code)
      2'h0:    gain_kohm = 8'hC8;
      2'h1:    gain_kohm = 8'h64;
      2'h2:    gain_kohm = 8'h32;
      default: gain_kohm = 8'h19;
    endcase
  endfunction

  // one channel's pair in the companion word
  function automatic logic [1:0] companion_gain(input logic [15:0] word,
                                                input int          ch);
    companion_gain = word[2*ch-2 +: 2];
  endfunction

  // fine offset doubles as the gap length when gapped mode is on
  function automatic logic [4:0] fine_field(input logic [15:0] word);
    fine_field = word[POS_FINE_MSB:POS_FINE_LSB];
  endfunction

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  // reserved bits are kept as written so a read returns the whole word
  logic [15:0] window_q;
  logic [15:0] mode_gain_q;
  logic [15:0] ch_gain_q;
  logic [15:0] mode_sel_q;
  logic [15:0] sample_opt_q;

  asc_reg16 #(.RESET_VALUE(RST_WINDOW)) u_window (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (hit(req, OFS_SLOT_A_WINDOW)),
    .wdata   (req.wdata),
    .q       (window_q)
  );

  asc_reg16 #(.RESET_VALUE(RST_MODE_GAIN)) u_mode_gain (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (hit(req, OFS_SLOT_A_MODE_GAIN)),
    .wdata   (req.wdata),
    .q       (mode_gain_q)
  );

  asc_reg16 #(.RESET_VALUE(RST_CH_GAIN)) u_ch_gain (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (hit(req, OFS_SLOT_A_CH_GAIN)),
    .wdata   (req.wdata),
    .q       (ch_gain_q)
  );

  asc_reg16 #(.RESET_VALUE(RST_MODE_SEL)) u_mode_sel (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (hit(req, OFS_INT_MODE_SELECT)),
    .wdata   (req.wdata),
    .q       (mode_sel_q)
  );

  asc_reg16 #(.RESET_VALUE(RST_SAMPLE_OPT)) u_sample_opt (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (hit(req, OFS_INT_SAMPLE_OPTS)),
    .wdata   (req.wdata),
    .q       (sample_opt_q)
  );

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [15:0] rdata_nxt;
  logic        rhit_nxt;

  // a write in the same cycle is not stored yet, so the old word returns
  // read back last written word
  always_comb begin
    rhit_nxt  = 1'b1;
    rdata_nxt = 16'h0000;
    case (req.addr)
      OFS_SLOT_A_WINDOW:    rdata_nxt = window_q;
      OFS_SLOT_A_MODE_GAIN: rdata_nxt = mode_gain_q;
      OFS_SLOT_A_CH_GAIN:   rdata_nxt = ch_gain_q;
      OFS_INT_MODE_SELECT:  rdata_nxt = mode_sel_q;
      OFS_INT_SAMPLE_OPTS:  rdata_nxt = sample_opt_q;
      default:              rhit_nxt  = 1'b0;
    endcase
  end

  // unmapped reads answer zero with hit low rather than stalling the port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.rd;
      rsp.hit   <= req.rd && rhit_nxt;
      rsp.rdata <= req.rd ? rdata_nxt : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // gain resolution
  // ----------------------------------------------------------------------
  logic [3:0][1:0] gain_nxt;
  logic [1:0]      shared_gain;
  logic            per_ch;

  assign shared_gain = mode_gain_q[POS_GAIN_MSB:POS_GAIN_LSB];
  assign per_ch      = mode_gain_q[POS_PER_CH_EN];

  always_comb begin
    // companion word is kept but ignored while per-channel gain is off
    // one code for all channels
    gain_nxt = {4{shared_gain}};
    if (per_ch) begin
      gain_nxt[0] = shared_gain;
      for (int c = 1; c < 4; c++) begin
        gain_nxt[c] = companion_gain(ch_gain_q, c);
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode and window outputs
  // ----------------------------------------------------------------------
  // outputs lag the register by one cycle so that every output is a flop
  // reset values mirror the register defaults, never a zero window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= '0;
      cfg.first_slot_window_width  <= RST_WIDTH;
      cfg.first_slot_window_coarse <= RST_COARSE;
      cfg.first_slot_window_fine   <= RST_FINE;
      cfg.first_slot_chain_mode    <=
        RST_MODE_GAIN[POS_CHAIN_MSB:POS_CHAIN_LSB];
      cfg.first_slot_amp_kohm      <= {4{gain_kohm(2'h0)}};
    end else begin
      cfg.second_slot_integration_enable <= mode_sel_q[POS_SECOND_SLOT_INT];
      cfg.first_slot_integration_enable <= mode_sel_q[POS_FIRST_SLOT_INT];
      cfg.second_slot_single_pair <= sample_opt_q[POS_SECOND_SINGLE];
      cfg.first_slot_single_pair <= sample_opt_q[POS_FIRST_SINGLE];
      // slot B fine offset lives outside this bank; only slot A gets a gap
      // gap length from fine offset
      cfg.integration_gap_enable <= sample_opt_q[POS_GAP_ENABLE];
      cfg.first_slot_gap_us <= sample_opt_q[POS_GAP_ENABLE] ?
                               fine_field(window_q) : 5'h00;
      cfg.first_slot_window_width <= window_q[POS_WIDTH_MSB:POS_WIDTH_LSB];
      cfg.first_slot_window_coarse <= window_q[POS_COARSE_MSB:POS_COARSE_LSB];
      cfg.first_slot_window_fine <= fine_field(window_q);
      cfg.first_slot_chain_mode <= mode_gain_q[POS_CHAIN_MSB:POS_CHAIN_LSB];
      cfg.first_slot_per_channel_gain_enable <= per_ch;
      cfg.first_slot_amp_gain <= gain_nxt;
      for (int i = 0; i < 4; i++) begin
        cfg.first_slot_amp_kohm[i] <= gain_kohm(gain_nxt[i]);
      end
    end
  end

endmodule // asc_config_regs
`default_nettype wire

// >>> rtl/asc_reg16.sv
// Purpose: one 16-bit read-write configuration register
// Assumes: synchronous active-high reset
// Notes:   whole word written at once; no byte lanes on the host port
`timescale 1ns/10ps
`default_nettype none
module asc_reg16 #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // write side
  input  wire logic        we,
  input  wire logic [15:0] wdata,
  // stored value
  output var  logic [15:0] q
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (we) begin
      q <= wdata;
    end
  end

endmodule // asc_reg16
`default_nettype wire

// >>> tb/asc_config_regs_checker.sv
// Purpose: port-level assertions for the slot config bank
// Assumes: single clock domain, synchronous active-high reset
// Notes:   cfg follows a write two edges after the write is taken
`timescale 1ns/10ps
`default_nettype none
module asc_config_regs_checker
  import asc_pkg::*;
(
  // clock and reset
  input wire logic     ref_clk,
  input wire logic     rst,
  // watched ports
  input wire asc_req_t req,
  input wire asc_rsp_t rsp,
  input wire asc_cfg_t cfg
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        addr_hit;
  logic [15:0] wd1;
  logic [15:0] wd2;
  assign addr_hit = req.addr inside {OFS_SLOT_A_WINDOW, OFS_SLOT_A_MODE_GAIN,
                    OFS_SLOT_A_CH_GAIN, OFS_INT_MODE_SELECT, OFS_INT_SAMPLE_OPTS};
  // write data two edges back, to match the cfg delay
  always_ff @(posedge ref_clk) begin
    wd1 <= req.wdata;
    wd2 <= wd1;
  end
  sequence s_wr(logic [7:0] a);
    req.wr && req.addr == a;
  endsequence
  property p_read_ans;
    req.rd |=> rsp.valid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read not answered");
  property p_no_ans;
    !req.rd |=> !rsp.valid && rsp.rdata == 16'h0000;
  endproperty
  a_no_ans: assert property (p_no_ans)
    else $error("answer without read");
  property p_unmapped;
    req.rd && !addr_hit |=> !rsp.hit && rsp.rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read hit");
  property p_mode;
    s_wr(OFS_INT_MODE_SELECT) ##2 1'b1 |-> {cfg.second_slot_integration_enable,
      cfg.first_slot_integration_enable} == wd2[13:12];
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode bits wrong");
  property p_opts;
    s_wr(OFS_INT_SAMPLE_OPTS) ##2 1'b1 |-> {cfg.integration_gap_enable,
      cfg.second_slot_single_pair, cfg.first_slot_single_pair} == wd2[7:5];
  endproperty
  a_opts: assert property (p_opts)
    else $error("option bits wrong");
  property p_window;
    s_wr(OFS_SLOT_A_WINDOW) ##2 1'b1 |-> {cfg.first_slot_window_width,
      cfg.first_slot_window_coarse, cfg.first_slot_window_fine} == wd2;
  endproperty
  a_window: assert property (p_window)
    else $error("window fields wrong");
  property p_chain;
    s_wr(OFS_SLOT_A_MODE_GAIN) ##2 1'b1 |-> cfg.first_slot_chain_mode ==
      wd2[15:8] && cfg.first_slot_per_channel_gain_enable == wd2[6];
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain mode wrong");
  property p_gap;
    cfg.first_slot_gap_us == (cfg.integration_gap_enable ?
      cfg.first_slot_window_fine : 5'h00);
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong");
  property p_shared;
    !cfg.first_slot_per_channel_gain_enable |-> cfg.first_slot_amp_gain ==
      {4{cfg.first_slot_amp_gain[0]}};
  endproperty
  a_shared: assert property (p_shared)
    else $error("gain not shared");
  property p_kohm;
    cfg.first_slot_amp_kohm[3] == (8'hC8 >> cfg.first_slot_amp_gain[3]);
  endproperty
  a_kohm: assert property (p_kohm) else $error("kohm code wrong");
endmodule // asc_config_regs_checker
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the slot config bank
// Assumes: requests driven on the falling edge
// Notes:   read answers are matched in order from a queue
`timescale 1ns/10ps
`default_nettype none
module testbench
  import asc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  asc_req_t req = '0;
  asc_rsp_t rsp;
  asc_cfg_t cfg;
  logic [16:0] exp_q[$];
  logic [15:0] mdl[logic [7:0]];
  logic [7:0] maps[5] = '{8'h39, 8'h42, 8'h55, 8'h58, 8'h5A};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  asc_config_regs DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp),
                       .cfg(cfg));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic init_mdl();
    mdl[8'h39] = 16'h22FC;
    mdl[8'h42] = 16'h1C38;
    mdl[8'h55] = 16'h0000;
    mdl[8'h58] = 16'h0000;
    mdl[8'h5A] = 16'h0000;
  endtask
  // a read taken with a write returns the old word
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [15:0] d);
    @(negedge ref_clk);
    req = '{wr:w, rd:r, addr:a, wdata:d};
    if (r) exp_q.push_back(mdl.exists(a) ? {1'b1, mdl[a]} : 17'h00000);
    if (w && mdl.exists(a)) mdl[a] = d;
  endtask
  task automatic cfg_chk();
    logic [15:0] w, g, c, m, o;
    logic [1:0]  e;
    @(negedge ref_clk);
    req = '0;
    repeat (3) @(negedge ref_clk);
    w = mdl[8'h39];
    g = mdl[8'h42];
    c = mdl[8'h55];
    m = mdl[8'h58];
    o = mdl[8'h5A];
    chk(cfg.first_slot_window_width, w[15:11]);
    chk(cfg.first_slot_window_coarse, w[10:5]);
    chk(cfg.first_slot_window_fine, w[4:0]);
    chk(cfg.first_slot_gap_us, o[7] ? w[4:0] : 5'h00);
    chk(cfg.integration_gap_enable, o[7]);
    chk(cfg.second_slot_integration_enable, m[13]);
    chk(cfg.first_slot_integration_enable, m[12]);
    chk(cfg.second_slot_single_pair, o[6]);
    chk(cfg.first_slot_single_pair, o[5]);
    chk(cfg.first_slot_chain_mode, g[15:8]);
    chk(cfg.first_slot_per_channel_gain_enable, g[6]);
    for (int k = 0; k < 4; k++) begin
      e = (k == 0 || !g[6]) ? g[1:0] : c[2*k-2 +: 2];
      chk(cfg.first_slot_amp_gain[k], e);
      chk(cfg.first_slot_amp_kohm[k], 8'hC8 >> e);
    end
  endtask
  always @(negedge ref_clk) begin
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({rsp.hit, rsp.rdata}, exp_q.pop_front());
    end
  end
  // bench runs about 160 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0]  ra;
    logic [15:0] rnd;
    void'($urandom(32'h0E290C20));
    init_mdl();
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    foreach (maps[i]) op(1'b0, 1'b1, maps[i], 16'h0000);
    op(1'b1, 1'b0, 8'h40, 16'hFFFF);
    op(1'b0, 1'b1, 8'h40, 16'h0000);
    cfg_chk();
    repeat (60) begin
      ra = maps[$urandom_range(4, 0)];
      rnd = 16'($urandom);
      // software only ever programs a legal chain mode code
      if (ra == 8'h42) rnd[15:8] = rnd[0] ? 8'h1D : 8'h1C;
      if ($urandom_range(1, 0)) op(1'b1, 1'b0, ra, rnd);
      else op(1'b0, 1'b1, ra, 16'h0000);
    end
    cfg_chk();
    op(1'b1, 1'b0, 8'h55, 16'h0039);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 1'b1, 8'h42, {k[0] ? 8'h1D : 8'h1C, 1'b0, k[2], 4'hE, k[1:0]});
      op(1'b1, 1'b0, 8'h5A, {8'h00, k[0], k[1], k[2], 5'h00});
      op(1'b1, 1'b1, 8'h58, {2'b00, k[1:0], 12'h000});
      // path connection word lives outside the bank; the write is dropped
      op(1'b1, 1'b0, 8'h43, k[0] ? PATH_DIGITAL : 16'hADA5);
      cfg_chk();
    end
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    init_mdl();
    foreach (maps[i]) op(1'b0, 1'b1, maps[i], 16'h0000);
    cfg_chk();
    chk(exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule // testbench
bind asc_config_regs asc_config_regs_checker chk_i (.ref_clk(ref_clk),
  .rst(rst), .req(req), .rsp(rsp), .cfg(cfg));
`default_nettype wire
